// [rspc_pkg.sv]
package rspc_pkg;
  // register byte addresses: printed offsets are not all multiples of four, so index * 4
  localparam logic [7:0] REG_IDX_CFG_BASE = 8'h40;
  localparam logic [7:0] REG_IDX_DRAM_CTL_TWO = 8'h35;
  localparam logic [7:0] REG_IDX_FEATURE_ONE = 8'hA0;
  localparam logic [7:0] REG_IDX_STRAP_STATUS = 8'hF0;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = {REG_IDX_CFG_BASE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DRAM_CTL_TWO = {REG_IDX_DRAM_CTL_TWO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FEATURE_ONE = {REG_IDX_FEATURE_ONE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STRAP_STATUS = {REG_IDX_STRAP_STATUS, 2'b00};
  // field positions
  localparam int BIT_RESUME_EN = 0;
  localparam int BIT_MULT_RB = 3;
  localparam int BIT_DACK_ALT = 3;
  localparam logic [7:0] DRAM_CTL_TWO_WMASK = 8'hF7;
  localparam logic [7:0] CFG_BASE_RESET = 8'h00;
  localparam logic [7:0] DRAM_CTL_TWO_RESET = 8'h00;
  localparam logic [7:0] FEATURE_ONE_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // raw strap pin levels
  typedef struct packed {
    logic sys_addr_bit_zero;
    logic sys_addr_bit_one;
    logic ide_buffer_enable;
    logic bus_cycle_indicator;
    logic mem_addr_top_bit;
    logic row_strobe_five;
    logic mem_data_direction;
    logic proc_mode_strap_a;
    logic proc_mode_strap_b;
    logic proc_clock_mult_strap;
    logic proc_bus_style_strap;
    logic sys_byte_high_enable;
    logic nmi_strap;
    logic irq_request_pin;
  } rspc_straps_t;

  // defaults from the internal pulls
  localparam rspc_straps_t STRAP_DEFAULT = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
                                            1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  // pull direction: 1 = pull-up enabled, 0 = pull-down enabled
  localparam rspc_straps_t PULL_UP_SEL = STRAP_DEFAULT;

  // decoded configuration
  typedef struct packed {
    logic l2_cache_en;
    logic ide_buf_active_high;
    logic clk_in_1x;
    logic fb_clk_delay;
    logic cpu_clk_delay;
    logic legacy_mem;
    logic stop_clock_en;
    logic proc_clk_2x;
    logic new_bus_style;
    logic resume_strap;
    logic cache_addr25_sel;
    logic cpu_5v;
    logic at_bus_3v3;
  } rspc_cfg_t;

  // Avalon-MM request
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } rspc_avm_req_t;
endpackage

// [rspc_strap_cfg.sv]
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module rspc_strap_cfg
  import rspc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic primary_reset_n_i,
  input rspc_straps_t strap_pins_i,
  input rspc_avm_req_t avm_req_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  output logic avm_resume_reset_route_o,
  output rspc_cfg_t cfg_o,
  output logic secondary_reset_out_n_o,
  output logic strap_pull_en_o,
  output logic dma_alt_pins_o,
  output logic dma_pins_on_mem_o,
  output logic dma_ack_ch2_dedicated_o,
  output logic [2:0] dma_ack_code_o,
  input wire logic [2:0] dma_ack_code_i,
  input wire logic ext_event_in_one_i,
  input wire logic ext_event_in_two_i,
  input wire logic battery_low_in_i,
  input wire logic battery_very_low_in_i,
  input wire logic muxed_event_in_i,
  output logic [3:0] event_inputs_o
);
  logic rst_s1_r;
  logic rst_n;
  logic [2:0] prst_sync_r;
  logic prst_lvl_r;
  logic captured_r;
  rspc_straps_t strap_s1_r;
  rspc_straps_t strap_s2_r;
  rspc_straps_t strap_s3_r;
  rspc_straps_t latched_r;
  rspc_cfg_t cfg_nxt;
  logic [7:0] cfg_base_r;
  logic [7:0] dram_ctl_two_r;
  logic [7:0] feature_one_r;
  logic ack_pending_r;
  logic [3:0] ev_s1_r;
  logic [3:0] ev_s2_r;
  logic [3:0] ev_s3_r;
  logic [3:0] ev_r;
  logic muxed_s1_r;
  logic muxed_s2_r;
  logic muxed_s3_r;
  logic rise_pending;
  logic req_hit;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // primary reset pin: three flops, change taken when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prst_sync_r <= 3'b000;
      prst_lvl_r <= 1'b0;
    end else begin
      prst_sync_r <= {prst_sync_r[1:0], primary_reset_n_i};
      if (prst_sync_r[1] == prst_sync_r[2]) begin
        prst_lvl_r <= prst_sync_r[2];
      end
    end
  end
  assign rise_pending = (prst_sync_r[1] == prst_sync_r[2]) && prst_sync_r[2] && !prst_lvl_r;

  // strap pins share the same three-stage path so data lines up with the edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_r <= STRAP_DEFAULT;
      strap_s2_r <= STRAP_DEFAULT;
      strap_s3_r <= STRAP_DEFAULT;
    end else begin
      strap_s1_r <= strap_pins_i;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
    end
  end

  // capture once on the primary reset release; later pin activity ignored
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      latched_r <= STRAP_DEFAULT;
      captured_r <= 1'b0;
    end else if (!prst_lvl_r && !rise_pending) begin
      captured_r <= 1'b0; // re-arm only on a new hardware reset
    end else if (rise_pending && !captured_r) begin
      latched_r <= strap_s3_r;
      captured_r <= 1'b1;
    end
  end

  // secondary reset held until one cycle after capture, so capture sees it active
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      secondary_reset_out_n_o <= 1'b0;
      strap_pull_en_o <= 1'b1;
    end else begin
      secondary_reset_out_n_o <= captured_r;
      strap_pull_en_o <= !captured_r; // pulls cost power once lines are driven
    end
  end

  // decode of the latched levels
  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.l2_cache_en = !latched_r.sys_addr_bit_zero;
    cfg_nxt.ide_buf_active_high = !latched_r.ide_buffer_enable;
    cfg_nxt.clk_in_1x = latched_r.bus_cycle_indicator;
    cfg_nxt.fb_clk_delay = latched_r.mem_addr_top_bit;
    cfg_nxt.cpu_clk_delay = !latched_r.row_strobe_five;
    cfg_nxt.legacy_mem = latched_r.mem_data_direction;
    cfg_nxt.stop_clock_en = latched_r.proc_mode_strap_a & latched_r.proc_mode_strap_b;
    cfg_nxt.proc_clk_2x = latched_r.proc_clock_mult_strap;
    cfg_nxt.new_bus_style = latched_r.proc_bus_style_strap;
    cfg_nxt.resume_strap = latched_r.sys_addr_bit_one;
    cfg_nxt.cache_addr25_sel = latched_r.sys_byte_high_enable;
    cfg_nxt.cpu_5v = !latched_r.nmi_strap;
    cfg_nxt.at_bus_3v3 = !latched_r.irq_request_pin;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_o <= '0;
    end else begin
      cfg_o <= cfg_nxt;
    end
  end

  // bus slave: one wait cycle, then accept
  assign req_hit = (avm_req_i.read || avm_req_i.write) && !ack_pending_r;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_pending_r <= 1'b0;
      avm_waitrequest_o <= 1'b1;
    end else begin
      ack_pending_r <= req_hit;
      avm_waitrequest_o <= !req_hit;
    end
  end

  // register writes take effect at the accepting edge; options live-switchable
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_base_r <= CFG_BASE_RESET;
      dram_ctl_two_r <= DRAM_CTL_TWO_RESET;
      feature_one_r <= FEATURE_ONE_RESET; // firmware must set it
    end else if (ack_pending_r && avm_req_i.write && avm_req_i.byteenable[0]) begin
      unique case (avm_req_i.address)
        ADDR_CFG_BASE: cfg_base_r <= avm_req_i.writedata[7:0];
        ADDR_DRAM_CTL_TWO: dram_ctl_two_r <= avm_req_i.writedata[7:0] & DRAM_CTL_TWO_WMASK;
        ADDR_FEATURE_ONE: feature_one_r <= avm_req_i.writedata[7:0];
        default: ;
      endcase
    end
  end

  // read data registered at the edge that drops waitrequest, one edge before the accepting edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avm_readdata_o <= UNMAPPED_READ;
    end else if (req_hit && avm_req_i.read) begin
      unique case (avm_req_i.address)
        ADDR_CFG_BASE: avm_readdata_o <= {24'h000000, cfg_base_r};
        ADDR_DRAM_CTL_TWO: begin
          avm_readdata_o <= {24'h000000, dram_ctl_two_r};
          avm_readdata_o[BIT_MULT_RB] <= !cfg_o.proc_clk_2x; // 1 = 1x
        end
        ADDR_FEATURE_ONE: avm_readdata_o <= {24'h000000, feature_one_r};
        ADDR_STRAP_STATUS: avm_readdata_o <= {19'h00000, cfg_o};
        default: avm_readdata_o <= UNMAPPED_READ;
      endcase
    end
  end

  // pin routing outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avm_resume_reset_route_o <= 1'b0;
      dma_alt_pins_o <= 1'b0;
      dma_pins_on_mem_o <= 1'b0;
      dma_ack_ch2_dedicated_o <= 1'b1;
      dma_ack_code_o <= 3'b000;
    end else begin
      avm_resume_reset_route_o <= cfg_o.resume_strap & cfg_base_r[BIT_RESUME_EN];
      dma_alt_pins_o <= feature_one_r[BIT_DACK_ALT];
      dma_pins_on_mem_o <= cfg_o.legacy_mem;
      dma_ack_ch2_dedicated_o <= 1'b1;
      dma_ack_code_o <= dma_ack_code_i;
    end
  end

  // event pins synchronised; with the feature bit set only the muxed input counts
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1_r <= 4'h0;
      ev_s2_r <= 4'h0;
      ev_s3_r <= 4'h0;
      muxed_s1_r <= 1'b0;
      muxed_s2_r <= 1'b0;
      muxed_s3_r <= 1'b0;
      ev_r <= 4'h0;
    end else begin
      ev_s1_r <= {battery_very_low_in_i, battery_low_in_i, ext_event_in_two_i,
                  ext_event_in_one_i};
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
      muxed_s1_r <= muxed_event_in_i;
      muxed_s2_r <= muxed_s1_r;
      muxed_s3_r <= muxed_s2_r;
      if (feature_one_r[BIT_DACK_ALT]) begin
        if (muxed_s2_r == muxed_s3_r) begin
          ev_r <= {4{muxed_s3_r}};
        end
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (ev_s2_r[i] == ev_s3_r[i]) begin
            ev_r[i] <= ev_s3_r[i];
          end
        end
      end
    end
  end
  assign event_inputs_o = ev_r;

  // capture happens while secondary reset is still asserted
  chk_capture_in_reset: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rise_pending && !captured_r) |-> !secondary_reset_out_n_o)
    else $error("capture outside secondary reset");
  chk_pulls_off: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(captured_r) |=> !strap_pull_en_o)
    else $error("pulls stay on after reset");
  chk_latch_holds: assert property (@(posedge clk_i) disable iff (!rst_n)
    captured_r && $past(captured_r) |-> $stable(latched_r))
    else $error("latched straps changed");
  chk_stop_clock: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.stop_clock_en |-> $past(latched_r.proc_mode_strap_a && latched_r.proc_mode_strap_b))
    else $error("stop clock without both straps");
  chk_readback_mult: assert property (@(posedge clk_i) disable iff (!rst_n)
    (req_hit && avm_req_i.read && avm_req_i.address == ADDR_DRAM_CTL_TWO)
    |=> avm_readdata_o[BIT_MULT_RB] == !$past(cfg_o.proc_clk_2x))
    else $error("multiplier readback wrong");
  chk_dma_alt: assert property (@(posedge clk_i) disable iff (!rst_n)
    dma_alt_pins_o == $past(feature_one_r[BIT_DACK_ALT]))
    else $error("dma alternate routing lag");
  chk_ch2_always: assert property (@(posedge clk_i) disable iff (!rst_n)
    dma_ack_ch2_dedicated_o)
    else $error("channel two lost");
  chk_resume_route: assert property (@(posedge clk_i) disable iff (!rst_n)
    avm_resume_reset_route_o |-> $past(cfg_o.resume_strap && cfg_base_r[BIT_RESUME_EN]))
    else $error("resume routing without strap and bit");
  chk_cache_low: assert property (@(posedge clk_i) disable iff (!rst_n)
    $past(captured_r, 2) |-> cfg_o.l2_cache_en == !$past(latched_r.sys_addr_bit_zero))
    else $error("cache decode wrong");

  // decode checks: every option compares with the latched level one cycle earlier
  // all defaults decode to zero, so the first edge after reset cannot misfire
  chk_ide_polarity: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.ide_buf_active_high == !$past(latched_r.ide_buffer_enable))
    else $error("ide buffer polarity wrong");
  chk_input_clock: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.clk_in_1x == $past(latched_r.bus_cycle_indicator))
    else $error("input clock select wrong");
  chk_fb_delay: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.fb_clk_delay == $past(latched_r.mem_addr_top_bit))
    else $error("feedback clock delay wrong");
  chk_cpu_delay: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.cpu_clk_delay == !$past(latched_r.row_strobe_five))
    else $error("processor clock delay wrong");
  chk_legacy_mem: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.legacy_mem == $past(latched_r.mem_data_direction))
    else $error("memory scheme select wrong");
  chk_proc_mult: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.proc_clk_2x == $past(latched_r.proc_clock_mult_strap))
    else $error("processor multiplier wrong");
  chk_bus_style: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.new_bus_style == $past(latched_r.proc_bus_style_strap))
    else $error("bus style select wrong");
  chk_resume_strap: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.resume_strap == $past(latched_r.sys_addr_bit_one))
    else $error("resume strap decode wrong");
  chk_cache_addr: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.cache_addr25_sel == $past(latched_r.sys_byte_high_enable))
    else $error("cache address select wrong");
  chk_cpu_level: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.cpu_5v == !$past(latched_r.nmi_strap))
    else $error("processor level wrong");
  chk_bus_level: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_o.at_bus_3v3 == !$past(latched_r.irq_request_pin))
    else $error("expansion bus level wrong");

  // capture takes the three-stage copy of the pins
  chk_capture_data: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rise_pending && !captured_r) |=> latched_r == $past(strap_s3_r))
    else $error("captured straps differ from pins");

  // release order: capture, then secondary reset off and pulls off two edges on
  sequence seq_strap_capture;
    rise_pending && !captured_r;
  endsequence
  sequence seq_reset_released;
    secondary_reset_out_n_o && !strap_pull_en_o;
  endsequence
  chk_release_order: assert property (@(posedge clk_i) disable iff (!rst_n)
    seq_strap_capture |=> ##1 seq_reset_released)
    else $error("secondary reset not released after capture");

  // pulls track the secondary reset exactly, on only while secondary reset is asserted; the board drives level_i one cycle behind it
  chk_pulls_in_reset: assert property (@(posedge clk_i) disable iff (!rst_n)
    strap_pull_en_o == !secondary_reset_out_n_o)
    else $error("pulls out of step with reset");

  // legacy memory strap puts the DMA pins on the memory pins
  chk_mem_pins_dma: assert property (@(posedge clk_i) disable iff (!rst_n)
    dma_pins_on_mem_o == $past(cfg_o.legacy_mem))
    else $error("memory pins routing lag");

  // run-time writes to the feature register land at the accepting edge
  chk_feature_write: assert property (@(posedge clk_i) disable iff (!rst_n)
    (ack_pending_r && avm_req_i.write && avm_req_i.byteenable[0] &&
     avm_req_i.address == ADDR_FEATURE_ONE) |=> feature_one_r == $past(avm_req_i.writedata[7:0]))
    else $error("feature write lost");

  // decoded options stay put once capture is two edges old
  chk_cfg_holds: assert property (@(posedge clk_i) disable iff (!rst_n)
    captured_r && $past(captured_r) && $past(captured_r, 2) |-> $stable(cfg_o))
    else $error("decoded options changed");

  // event routing in both feature settings
  chk_alt_events: assert property (@(posedge clk_i) disable iff (!rst_n)
    (feature_one_r[BIT_DACK_ALT] && muxed_s2_r == muxed_s3_r)
    |=> ev_r == {4{$past(muxed_s3_r)}})
    else $error("muxed event not routed");
  chk_norm_events: assert property (@(posedge clk_i) disable iff (!rst_n)
    (!feature_one_r[BIT_DACK_ALT] && ev_s2_r == ev_s3_r) |=> ev_r == $past(ev_s3_r))
    else $error("event pins not routed");

  // waitrequest drops for one cycle only, so each request is taken once
  chk_wait_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    !avm_waitrequest_o |=> avm_waitrequest_o)
    else $error("waitrequest low twice");
endmodule

// [rspc_strap_board.sv]
`timescale 1ns/1ps
// board strap drivers: one register per strap pin, never tristated
module rspc_strap_board
  import rspc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sec_reset_n_i,
  input rspc_straps_t level_i,
  output rspc_straps_t pins_o
);
  initial pins_o = STRAP_DEFAULT;
  // level_i driven only while secondary reset is low; once released the lines
  // change every cycle so that a late or repeated sample is caught
  always @(posedge clk_i) begin
    if (!sec_reset_n_i) begin
      pins_o <= level_i;
    end else begin
      pins_o <= ~pins_o;
    end
  end
endmodule

// [tb_rspc_strap_cfg.sv]
`timescale 1ns/1ps
module tb_rspc_strap_cfg;
  import rspc_pkg::*;
  logic clk_i, reset_n_i, primary_reset_n_i;
  rspc_straps_t lvl, pins;
  rspc_avm_req_t req;
  rspc_cfg_t cfg;
  logic [31:0] rdata;
  logic wait_r, route, sec_n, pull_en, alt, on_mem, ch2;
  logic [2:0] code_i, code_o;
  logic e1, e2, bl, bvl, mux;
  logic [3:0] ev;
  int err_count, comparisons;
  logic [31:0] exp_q[$];

  rspc_strap_board board (.clk_i(clk_i), .sec_reset_n_i(sec_n), .level_i(lvl), .pins_o(pins));
  rspc_strap_cfg DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .primary_reset_n_i(primary_reset_n_i), .strap_pins_i(pins), .avm_req_i(req),
    .avm_readdata_o(rdata), .avm_waitrequest_o(wait_r), .avm_resume_reset_route_o(route),
    .cfg_o(cfg), .secondary_reset_out_n_o(sec_n), .strap_pull_en_o(pull_en),
    .dma_alt_pins_o(alt), .dma_pins_on_mem_o(on_mem), .dma_ack_ch2_dedicated_o(ch2),
    .dma_ack_code_o(code_o), .dma_ack_code_i(code_i), .ext_event_in_one_i(e1),
    .ext_event_in_two_i(e2), .battery_low_in_i(bl), .battery_very_low_in_i(bvl),
    .muxed_event_in_i(mux), .event_inputs_o(ev));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_cfg(input rspc_cfg_t got, input rspc_cfg_t exp);
    check_word({19'h0, got}, {19'h0, exp}, "config");
  endtask

  // a wait that runs out ends the run through the closing report
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      $display("[ERR] %0t wait limit reached", $time);
      conclude();
    end
  endtask

  // expected decode of one strap set
  function automatic rspc_cfg_t decode(input rspc_straps_t s);
    decode = '{~s.sys_addr_bit_zero, ~s.ide_buffer_enable, s.bus_cycle_indicator,
      s.mem_addr_top_bit, ~s.row_strobe_five, s.mem_data_direction,
      s.proc_mode_strap_a & s.proc_mode_strap_b, s.proc_clock_mult_strap,
      s.proc_bus_style_strap, s.sys_addr_bit_one, s.sys_byte_high_enable,
      ~s.nmi_strap, ~s.irq_request_pin};
  endfunction

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic [9:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{address: a, read: !wr, write: wr, byteenable: 4'hF, writedata: {24'h0, d}};
    do begin
      @(negedge clk_i);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    give_up(n, 50);
    @(posedge clk_i);
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(a, 1'b0, 8'h00);
  endtask

  // read results are matched in order against the noted expectations
  always @(negedge clk_i) begin
    if (req.read && wait_r === 1'b0) begin
      if (exp_q.size() == 0) check_word(rdata, 32'hFFFF_FFFF, "unexpected read");
      else check_word(rdata, exp_q.pop_front(), "read data");
    end
  end

  task automatic wait_sec(input logic want);
    int n;
    n = 0;
    while (sec_n !== want && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    give_up(n, 100);
  endtask

  task automatic ev_check(input logic f);
    logic [4:0] r;
    r = 5'($urandom);
    {mux, bvl, bl, e2, e1} <= r;
    code_i <= 3'($urandom);
    repeat (5) @(posedge clk_i);
    check_word(ev, f ? {4{r[4]}} : r[3:0], "event pins");
    check_word(alt, f, "alt pins");
    check_word(code_o, code_i, "ack code");
  endtask

  task automatic run(input int i);
    rspc_straps_t s;
    logic [7:0] d;
    logic r;
    s = rspc_straps_t'(14'($urandom));
    if (!s.nmi_strap) s.irq_request_pin = 1'b1;
    lvl <= s;
    primary_reset_n_i <= 1'b0;
    wait_sec(1'b0);
    repeat (4) @(posedge clk_i);
    check_word(pull_en, 1'b1, "pulls in reset");
    primary_reset_n_i <= 1'b1;
    wait_sec(1'b1);
    repeat (3) @(posedge clk_i);
    check_cfg(cfg, decode(s));
    check_word(pull_en, 1'b0, "pulls after reset");
    check_word(on_mem, s.mem_data_direction, "dma on memory pins");
    check_word(ch2, 1'b1, "channel two");
    if (i == 0) begin
      rd(ADDR_CFG_BASE, {24'h0, CFG_BASE_RESET});
      rd(ADDR_FEATURE_ONE, {24'h0, FEATURE_ONE_RESET});
    end
    d = 8'($urandom);
    bus(ADDR_DRAM_CTL_TWO, 1'b1, d);
    rd(ADDR_DRAM_CTL_TWO,
       {24'h0, d & DRAM_CTL_TWO_WMASK} | {28'h0, ~s.proc_clock_mult_strap, 3'h0});
    r = 1'($urandom);
    bus(ADDR_CFG_BASE, 1'b1, {7'h0, r});
    repeat (2) @(posedge clk_i);
    check_word(route, r & s.sys_addr_bit_one, "resume route");
    bus(ADDR_FEATURE_ONE, 1'b1, 8'h08);
    ev_check(1'b1);
    bus(ADDR_FEATURE_ONE, 1'b1, 8'h00);
    ev_check(1'b0);
    bus(10'h004, 1'b1, 8'hFF);
    rd(10'h004, UNMAPPED_READ);
    check_cfg(cfg, decode(s));
  endtask

  initial begin
    reset_n_i = 1'b0;
    primary_reset_n_i = 1'b0;
    req = '0;
    lvl = STRAP_DEFAULT;
    code_i = 3'h0;
    {mux, bvl, bl, e2, e1} = 5'h00;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'h3fe5));
    repeat (12) @(posedge clk_i);
    check_word(sec_n, 1'b0, "secondary reset held");
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      run(i);
      $display("strap test %0d done", i);
    end
    conclude();
  end
endmodule
